/* hw/cod_pkg.sv */
// shared constants for the clock output disable control
package cod_pkg;
  // one configuration word per output driver
  localparam int CFG_W = 16;
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 8;
  localparam int SEL_LSB = 8;
  localparam int SEL_W = 2;
  localparam int DIS_HIGH_BIT = 10;
  localparam int SYNC_BIT = 11;
  localparam int REG_OFF_BIT = 12;
  localparam int PIN0_MAP_BIT = 13;
  localparam int PIN1_MAP_BIT = 14;
  localparam int PWR_DN_BIT = 15;
  // factory image: half period 2 ticks, first pll, sync disable, gate pin 0 mapped, gate pin 1 unmapped
  localparam logic [CFG_W-1:0] CFG_DEFAULT = 16'h2801;
  // number of field writes the configuration memory accepts
  localparam logic [1:0] NVM_WRITES_MAX = 2'h2;
  localparam logic [1:0] NVM_WRITES_NONE = 2'h0;
  localparam logic [1:0] NVM_WRITES_ONE = 2'h1;

  typedef enum logic {COD_ST_LOAD, COD_ST_RUN} cod_state_e;

  function automatic logic [DIV_W-1:0] cod_div(input logic [CFG_W-1:0] w);
    cod_div = w[DIV_LSB +: DIV_W];
  endfunction

  function automatic logic [SEL_W-1:0] cod_sel(input logic [CFG_W-1:0] w);
    cod_sel = w[SEL_LSB +: SEL_W];
  endfunction
endpackage

/* hw/cod_slice_if.sv */
// control and result signals between the disable control and one output slice
`timescale 1ns/1ns
interface cod_slice_if;
  logic tick;
  logic div_rst;
  logic want_off;
  logic level_high;
  logic sync_mode;
  logic pwr_dn;
  logic [7:0] div_half;
  logic clk_pin;
  logic drv_on;
  logic oe;
  modport ctl (output tick, div_rst, want_off, level_high, sync_mode, pwr_dn, div_half,
               input clk_pin, drv_on, oe);
  modport slice (input tick, div_rst, want_off, level_high, sync_mode, pwr_dn, div_half,
                 output clk_pin, drv_on, oe);
endinterface

/* hw/cod_out_slice.sv */
// one output driver: divider, disable timing and disabled level
`timescale 1ns/1ns
module cod_out_slice (
  input wire logic clk,
  input wire logic sys_rst,
  cod_slice_if.slice s
);
  import cod_pkg::*;

  logic [DIV_W-1:0] cnt_r, cnt_nxt;
  logic phase_r, phase_nxt;
  logic en_r, en_nxt;
  logic pin_r, pin_nxt;
  logic oe_r, oe_nxt;
  logic wrap;
  logic boundary;

  // a period is high half then low half; the end of the low half closes it
  assign wrap = s.tick && (cnt_r >= s.div_half);
  assign boundary = wrap && !phase_r;

  // next divider, driver and pin state
  always_comb begin
    cnt_nxt = cnt_r;
    phase_nxt = phase_r;
    en_nxt = en_r;
    if (s.div_rst) begin
      cnt_nxt = '0; // R8
      phase_nxt = 1'b0;
      en_nxt = 1'b0;
    end else begin
      if (s.tick) begin
        cnt_nxt = wrap ? '0 : cnt_r + 8'h01;
      end
      if (wrap) begin
        phase_nxt = ~phase_r;
      end
      if (s.want_off) begin
        if (!s.sync_mode) begin
          en_nxt = 1'b0; // R7
        end else if (boundary) begin
          en_nxt = 1'b0; // R6
        end
      end else if (boundary) begin
        en_nxt = 1'b1; // re-enable on a period edge too, so no runt on the way back
      end
    end
    pin_nxt = en_nxt ? phase_nxt : s.level_high; // R5
    oe_nxt = !s.pwr_dn; // R9
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
      phase_r <= 1'b0;
      en_r <= 1'b0;
      pin_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      phase_r <= phase_nxt;
      en_r <= en_nxt;
      pin_r <= pin_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign s.clk_pin = pin_r;
  assign s.drv_on = en_r;
  assign s.oe = oe_r;

  property p_async_stop;
    @(posedge clk) disable iff (sys_rst)
    (en_r && s.want_off && !s.sync_mode && !s.div_rst) |=> (!en_r && (pin_r == $past(s.level_high)));
  endproperty
  a_async_stop: assert property (p_async_stop) else $error("async disable did not stop at once"); // R7

  property p_sync_wait;
    @(posedge clk) disable iff (sys_rst)
    (en_r && s.want_off && s.sync_mode && !boundary && !s.div_rst) |=> en_r;
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("sync disable cut a period short"); // R6

  property p_hold_level;
    @(posedge clk) disable iff (sys_rst)
    (!en_nxt && !s.div_rst) |=> (pin_r == $past(s.level_high));
  endproperty
  a_hold_level: assert property (p_hold_level) else $error("disabled pin not at selected level"); // R5
endmodule

/* hw/cod_top.sv */
// clock output disable control: causes, configuration load and image store
`timescale 1ns/1ns
// Notes on behaviour
// R1: an out-of-lock pll keeps clocking its outputs unless its disable-on-lock-loss option is set.
// R2: with that option set, outputs fed by the pll stay disabled for as long as it reports lock lost.
// R3: the crystal reference loss alarm disables every output while it stands, by default.
// R4: a keep-on option leaves outputs running during that alarm, with no accuracy promised.
// R5: a disabled driver holds its configured level, low or high.
// R6: in synchronous mode the driver finishes the running period before it turns off.
// R7: in asynchronous mode the driver stops at once.
// R8: all output dividers are reset at power-up load, on the reset pin and on hard reset.
// R9: inputs, output drivers and plls can each be powered down by configuration.
// R10: defaults are loaded from the configuration memory before any configured clock appears.
// R11: the configuration memory takes at most two writes and only the newest image is readable.
// R12: the host reaches the registers over one of two serial protocols chosen by a select pin.
// R13: the second protocol runs with either four wires or three wires with a shared data line.
// R14: by default gate pin 0 gates all outputs and gate pin 1 gates none until mapped.
// R15: register enables can turn outputs off even while the pins allow them, and default to none.
// R16: an output is off whenever any active cause applies.
module cod_top #(
  parameter int NOUT = 8,
  parameter int NPLL = 4,
  parameter int NIN = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [NPLL-1:0] pll_tick,
  input wire logic [NPLL-1:0] pll_lock_lost,
  input wire logic crystal_ref_loss_alarm,
  input wire logic output_gate_pin0_n,
  input wire logic output_gate_pin1_n,
  input wire logic reset_pin_n,
  input wire logic serial_sel_pin,
  input wire logic spi_3wire_pin,
  input wire logic [NPLL-1:0] lol_disable_en,
  input wire logic xtal_loss_keep_on,
  input wire logic hard_reset_req,
  input wire logic [NPLL-1:0] pll_pwr_dn,
  input wire logic [NIN-1:0] input_pwr_dn,
  input wire logic cfg_wr,
  input wire logic [$clog2(NOUT)-1:0] cfg_idx,
  input wire logic [cod_pkg::CFG_W-1:0] cfg_wdata,
  input wire logic nvm_burn,
  output logic [cod_pkg::CFG_W-1:0] cfg_rdata,
  output logic nvm_burn_refused,
  output logic [1:0] nvm_writes_used,
  output logic init_busy,
  output logic serial_is_i2c,
  output logic spi_is_3wire,
  output logic [NPLL-1:0] pll_run_en,
  output logic [NIN-1:0] input_run_en,
  output logic [NOUT-1:0] clk_out,
  output logic [NOUT-1:0] clk_oe,
  output logic [NOUT-1:0] drv_on
);
  import cod_pkg::*;

  localparam int IDX_W = $clog2(NOUT);
  localparam int SW = NPLL + 6;

  if (NOUT < 2 || NPLL < 1 || NPLL > (1 << SEL_W) || NIN < 1) begin : g_bad_params
    $error("cod_top: unsupported output, pll or input count");
  end

  // pins and async status: two flops before any logic looks at them
  logic [SW-1:0] meta_r, sync_r;
  logic [NPLL-1:0] lol_s;
  logic xtal_s, gate0_n_s, gate1_n_s, rst_pin_n_s, sel_s, wire3_s;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= {pll_lock_lost, crystal_ref_loss_alarm, output_gate_pin0_n, output_gate_pin1_n,
                 reset_pin_n, serial_sel_pin, spi_3wire_pin};
      sync_r <= meta_r;
    end
  end
  assign {lol_s, xtal_s, gate0_n_s, gate1_n_s, rst_pin_n_s, sel_s, wire3_s} = sync_r;

  // live configuration, image store and load sequencer
  cod_state_e state_r, state_nxt;
  logic [IDX_W-1:0] load_idx_r, load_idx_nxt;
  logic [CFG_W-1:0] cfg_r [NOUT];
  logic [CFG_W-1:0] cfg_nxt [NOUT];
  logic [CFG_W-1:0] nvm_r [2][NOUT];
  logic [1:0] writes_r, writes_nxt;
  logic rst_seen_r, rst_seen_nxt;
  logic burn_ok, restart;
  logic [CFG_W-1:0] image_word;

  // the newest written image hides the older ones; none written means the factory image
  always_comb begin
    image_word = CFG_DEFAULT; // R14 R15
    if (writes_r == NVM_WRITES_ONE) begin
      image_word = nvm_r[0][load_idx_r]; // R11
    end else if (writes_r == NVM_WRITES_MAX) begin
      image_word = nvm_r[1][load_idx_r]; // R11
    end
  end

  assign restart = hard_reset_req || (!rst_pin_n_s && rst_seen_r); // R8
  assign burn_ok = nvm_burn && (state_r == COD_ST_RUN) && (writes_r != NVM_WRITES_MAX); // R11

  // next load state, configuration words and write count
  always_comb begin
    state_nxt = state_r;
    load_idx_nxt = load_idx_r;
    writes_nxt = writes_r;
    cfg_nxt = cfg_r;
    // reset pin only counts once its synchronised level has been seen high
    rst_seen_nxt = rst_seen_r || rst_pin_n_s;
    if (burn_ok) begin
      writes_nxt = writes_r + NVM_WRITES_ONE; // R11
    end
    if (restart) begin
      state_nxt = COD_ST_LOAD; // R8
      load_idx_nxt = '0;
    end else begin
      case (state_r)
        COD_ST_LOAD: begin
          cfg_nxt[load_idx_r] = image_word; // R10
          if (load_idx_r == IDX_W'(NOUT - 1)) begin
            state_nxt = COD_ST_RUN;
          end else begin
            load_idx_nxt = load_idx_r + IDX_W'(1);
          end
        end
        COD_ST_RUN: begin
          if (cfg_wr && (32'(cfg_idx) < NOUT)) begin
            cfg_nxt[cfg_idx] = cfg_wdata; // R12
          end
        end
        default: begin
          state_nxt = COD_ST_LOAD;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= COD_ST_LOAD; // R10
      load_idx_r <= '0;
      writes_r <= NVM_WRITES_NONE;
      rst_seen_r <= 1'b0;
      for (int i = 0; i < NOUT; i++) begin
        cfg_r[i] <= CFG_DEFAULT;
      end
    end else begin
      state_r <= state_nxt;
      load_idx_r <= load_idx_nxt;
      writes_r <= writes_nxt;
      rst_seen_r <= rst_seen_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // image store has no reset: the write count decides what is visible
  always_ff @(posedge clk) begin
    if (burn_ok) begin
      for (int i = 0; i < NOUT; i++) begin
        nvm_r[writes_r[0]][i] <= cfg_r[i];
      end
    end
  end

  // disable causes per output
  logic [NOUT-1:0] off_nxt, off_r;
  logic [NOUT-1:0] lol_cause, pin_cause, reg_cause, sel_bad;
  logic xtal_cause;

  assign xtal_cause = xtal_s && !xtal_loss_keep_on; // R3 R4

  always_comb begin
    for (int i = 0; i < NOUT; i++) begin
      sel_bad[i] = 32'(cod_sel(cfg_r[i])) >= NPLL;
      lol_cause[i] = !sel_bad[i] && lol_s[cod_sel(cfg_r[i])] && lol_disable_en[cod_sel(cfg_r[i])]; // R1 R2
      pin_cause[i] = (cfg_r[i][PIN0_MAP_BIT] && gate0_n_s) || (cfg_r[i][PIN1_MAP_BIT] && gate1_n_s); // R14
      reg_cause[i] = cfg_r[i][REG_OFF_BIT]; // R15
      off_nxt[i] = lol_cause[i] || pin_cause[i] || reg_cause[i] || xtal_cause || sel_bad[i] // R16
                   || (!sel_bad[i] && pll_pwr_dn[cod_sel(cfg_r[i])]); // R9
    end
  end

  // status and power outputs all leave from flops
  logic [CFG_W-1:0] rdata_nxt;
  assign rdata_nxt = (32'(cfg_idx) < NOUT) ? cfg_r[cfg_idx] : '0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      off_r <= '1;
      cfg_rdata <= '0;
      nvm_burn_refused <= 1'b0;
      init_busy <= 1'b1;
      serial_is_i2c <= 1'b0;
      spi_is_3wire <= 1'b0;
      pll_run_en <= '0;
      input_run_en <= '0;
    end else begin
      off_r <= off_nxt;
      cfg_rdata <= rdata_nxt;
      nvm_burn_refused <= nvm_burn && !burn_ok; // R11
      init_busy <= (state_nxt == COD_ST_LOAD);
      serial_is_i2c <= sel_s; // R12
      spi_is_3wire <= !sel_s && wire3_s; // R13
      pll_run_en <= ~pll_pwr_dn; // R9
      input_run_en <= ~input_pwr_dn; // R9
    end
  end
  assign nvm_writes_used = writes_r;

  // one slice per output driver
  cod_slice_if sif [NOUT] ();
  for (genvar g = 0; g < NOUT; g++) begin : g_out
    assign sif[g].tick = !sel_bad[g] && pll_tick[cod_sel(cfg_r[g])];
    assign sif[g].div_rst = (state_r == COD_ST_LOAD); // R8 R10
    assign sif[g].want_off = off_r[g];
    assign sif[g].level_high = cfg_r[g][DIS_HIGH_BIT]; // R5
    assign sif[g].sync_mode = cfg_r[g][SYNC_BIT]; // R6 R7
    assign sif[g].pwr_dn = cfg_r[g][PWR_DN_BIT]; // R9
    assign sif[g].div_half = cod_div(cfg_r[g]);
    assign clk_out[g] = sif[g].clk_pin;
    assign clk_oe[g] = sif[g].oe;
    assign drv_on[g] = sif[g].drv_on;
    cod_out_slice u_slice (
      .clk(clk),
      .sys_rst(sys_rst),
      .s(sif[g])
    );
  end

  property p_lol_off;
    @(posedge clk) disable iff (sys_rst)
    (lol_s[0] && lol_disable_en[0] && cod_sel(cfg_r[0]) == '0) |=> off_r[0];
  endproperty
  a_lol_off: assert property (p_lol_off) else $error("lock loss with option set left output on"); // R2

  property p_lol_default;
    @(posedge clk) disable iff (sys_rst)
    (lol_disable_en == '0) |-> (lol_cause == '0);
  endproperty
  a_lol_default: assert property (p_lol_default) else $error("lock loss disabled output without option"); // R1

  property p_xtal_off;
    @(posedge clk) disable iff (sys_rst)
    (xtal_s && !xtal_loss_keep_on) |=> (&off_r);
  endproperty
  a_xtal_off: assert property (p_xtal_off) else $error("crystal loss left an output on"); // R3

  property p_xtal_keep;
    @(posedge clk) disable iff (sys_rst)
    (xtal_loss_keep_on && !lol_cause[0] && !pin_cause[0] && !reg_cause[0] && !sel_bad[0]
     && !pll_pwr_dn[cod_sel(cfg_r[0])]) |=> !off_r[0];
  endproperty
  a_xtal_keep: assert property (p_xtal_keep) else $error("keep-on option did not keep output on"); // R4

  property p_reg_off;
    @(posedge clk) disable iff (sys_rst)
    (cfg_r[0][REG_OFF_BIT] && !gate0_n_s && !gate1_n_s) |=> off_r[0];
  endproperty
  a_reg_off: assert property (p_reg_off) else $error("register enable did not override pins"); // R15

  property p_pin_restart;
    @(posedge clk) disable iff (sys_rst)
    (!rst_pin_n_s && rst_seen_r) |=> (state_r == COD_ST_LOAD) ##1 !drv_on[0];
  endproperty
  a_pin_restart: assert property (p_pin_restart) else $error("reset pin did not reset the dividers"); // R8

  property p_load_len;
    @(posedge clk) disable iff (sys_rst)
    ($rose(state_r == COD_ST_RUN)) |-> ($past(state_r, NOUT) == COD_ST_LOAD);
  endproperty
  a_load_len: assert property (p_load_len) else $error("load finished before every word was read"); // R10

  property p_burn_limit;
    @(posedge clk) disable iff (sys_rst)
    (nvm_burn && writes_r == NVM_WRITES_MAX) |=> (writes_r == NVM_WRITES_MAX && nvm_burn_refused);
  endproperty
  a_burn_limit: assert property (p_burn_limit) else $error("third image write was accepted"); // R11
endmodule

/* dv/cod_rx_model.sv */
// downstream clock receiver model: counts high pulses and runts on one pin
`timescale 1ns/1ns
module cod_rx_model (
  input wire logic clk,
  input wire logic pin,
  input wire logic oe,
  input wire logic chk_en,
  input wire logic [7:0] min_w,
  output int runts,
  output int pulses
);
  int hi_len = 0;
  int runt_n = 0;
  int pulse_n = 0;
  logic pin_q = 1'b0;
  // counters live inside so each output has a single driver
  assign runts = runt_n;
  assign pulses = pulse_n;
  // an unpowered driver reads as low here, since the receiver input is terminated
  always @(posedge clk) begin
    pin_q <= pin & oe;
    hi_len <= ((pin & oe) === 1'b1) ? hi_len + 1 : 0;
    if (chk_en && pin_q === 1'b1 && (pin & oe) !== 1'b1) begin
      pulse_n <= pulse_n + 1;
      // a short high pulse would upset a downstream pll, so it is counted
      if (hi_len < min_w) begin
        runt_n <= runt_n + 1;
      end
    end
  end
endmodule

/* dv/tb_clock_output_disable_control.sv */
// self-checking bench for the clock output disable control
`timescale 1ns/1ns
`define CHK(a,b) begin n_compared++; if ((a) !== (b)) begin miscompares++; $display("Error %0t: got %h want %h", $time, a, b); end end
`define WAIT(c,n) begin wc = 0; while ((c) !== 1'b1 && wc < n) begin @(negedge clk); wc++; end if ((c) !== 1'b1) begin miscompares++; $display("Error %0t: wait ran out", $time); close_out(); end end
module tb_clock_output_disable_control;
  import cod_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] pll_tick = 4'hf, pll_lock_lost = 4'h0, lol_disable_en = 4'h0, pll_pwr_dn = 4'h0, input_pwr_dn = 4'h0;
  logic crystal_ref_loss_alarm = 1'b0, xtal_loss_keep_on = 1'b0, hard_reset_req = 1'b0;
  logic output_gate_pin0_n = 1'b0, output_gate_pin1_n = 1'b0, reset_pin_n = 1'b1;
  logic serial_sel_pin = 1'b0, spi_3wire_pin = 1'b0, cfg_wr = 1'b0, nvm_burn = 1'b0, chk_en = 1'b0;
  logic [2:0] cfg_idx = 3'h0;
  logic [CFG_W-1:0] cfg_wdata = 16'h0000, cfg_rdata;
  logic nvm_burn_refused, init_busy, serial_is_i2c, spi_is_3wire;
  logic [1:0] nvm_writes_used;
  logic [3:0] pll_run_en, input_run_en;
  logic [7:0] clk_out, clk_oe, drv_on;
  int runts, pulses, wc, miscompares = 0, n_compared = 0;

  cod_top #(.NOUT(8), .NPLL(4), .NIN(4)) dut (.clk, .sys_rst, .pll_tick, .pll_lock_lost, .crystal_ref_loss_alarm,
    .output_gate_pin0_n, .output_gate_pin1_n, .reset_pin_n, .serial_sel_pin, .spi_3wire_pin, .lol_disable_en,
    .xtal_loss_keep_on, .hard_reset_req, .pll_pwr_dn, .input_pwr_dn, .cfg_wr, .cfg_idx, .cfg_wdata, .nvm_burn,
    .cfg_rdata, .nvm_burn_refused, .nvm_writes_used, .init_busy, .serial_is_i2c, .spi_is_3wire, .pll_run_en,
    .input_run_en, .clk_out, .clk_oe, .drv_on);

  cod_rx_model rx (.clk(clk), .pin(clk_out[0]), .oe(clk_oe[0]), .chk_en(chk_en), .min_w(8'h10), .runts(runts),
    .pulses(pulses));

  // 100 mhz clock
  initial begin
    forever #5 clk = ~clk;
  end

  task automatic close_out();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one-cycle write strobe, then a gap so strobes never merge
  task automatic wr(input logic [2:0] i, input logic [15:0] d);
    cfg_idx = i;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
    @(negedge clk);
  endtask

  // read data is registered, so allow two edges after the address settles
  task automatic rd(input logic [2:0] i, input logic [15:0] exp);
    cfg_idx = i;
    cyc(2);
    `CHK(cfg_rdata, exp)
  endtask

  task automatic burn(input logic [1:0] used, input logic refused);
    nvm_burn = 1'b1;
    @(negedge clk);
    nvm_burn = 1'b0;
    `CHK(nvm_writes_used, used)
    `CHK(nvm_burn_refused, refused)
  endtask

  // main sequence
  initial begin
    cyc(16);
    `CHK(init_busy, 1'b1)
    `CHK(clk_out, 8'h00)
    sys_rst = 1'b0;
    `WAIT(init_busy === 1'b0, 20)
    `CHK(wc >= 8 && wc <= 9, 1'b1)
    `WAIT(drv_on === 8'hff, 40)
    // lock loss on pll 0 only touches outputs it feeds
    wr(1, 16'h2901);
    pll_lock_lost = 4'h1;
    cyc(10);
    `CHK(drv_on, 8'hff)
    lol_disable_en = 4'h1;
    `WAIT(drv_on === 8'h02, 16)
    pll_lock_lost = 4'h0;
    `WAIT(drv_on === 8'hff, 16)
    lol_disable_en = 4'h0;
    wr(1, CFG_DEFAULT);
    // crystal alarm, then the keep-on override
    crystal_ref_loss_alarm = 1'b1;
    `WAIT(drv_on === 8'h00, 16)
    xtal_loss_keep_on = 1'b1;
    `WAIT(drv_on === 8'hff, 16)
    cyc(10);
    `CHK(drv_on, 8'hff)
    crystal_ref_loss_alarm = 1'b0;
    xtal_loss_keep_on = 1'b0;
    // gate pins: pin 1 unmapped by default, then mapped to output 2 only
    output_gate_pin1_n = 1'b1;
    cyc(10);
    `CHK(drv_on, 8'hff)
    wr(2, 16'h4801);
    `WAIT(drv_on === 8'hfb, 16)
    output_gate_pin0_n = 1'b1;
    `WAIT(drv_on === 8'h00, 16)
    output_gate_pin0_n = 1'b0;
    output_gate_pin1_n = 1'b0;
    wr(2, CFG_DEFAULT);
    `WAIT(drv_on === 8'hff, 16)
    wr(0, 16'h3801);
    `WAIT(drv_on === 8'hfe, 12)
    rd(0, 16'h3801);
    // immediate disable, low and high levels, long period so a wait would show
    for (int lv = 0; lv < 2; lv++) begin
      wr(0, lv[0] ? 16'h240f : 16'h200f);
      `WAIT(drv_on[0] === 1'b1, 80)
      output_gate_pin0_n = 1'b1;
      `WAIT(drv_on[0] === 1'b0, 6)
      `CHK(clk_out[0], lv[0])
      output_gate_pin0_n = 1'b0;
    end
    // synchronous disable at many phases must never cut a high half short
    wr(0, 16'h280f);
    // the level change from high to low lands two edges after the write and is no clock pulse
    cyc(2);
    chk_en = 1'b1;
    for (int k = 0; k < 8; k++) begin
      `WAIT(drv_on[0] === 1'b1, 80)
      cyc(k * 4 + 1);
      output_gate_pin0_n = 1'b1;
      `WAIT(drv_on[0] === 1'b0, 40)
      `CHK(clk_out[0], 1'b0)
      output_gate_pin0_n = 1'b0;
    end
    chk_en = 1'b0;
    `CHK(runts, 0)
    `CHK(pulses > 0, 1'b1)
    wr(0, CFG_DEFAULT);
    // power down of plls, inputs and one driver
    pll_pwr_dn = 4'h2;
    input_pwr_dn = 4'h5;
    wr(2, 16'h2901);
    wr(3, 16'ha801);
    cyc(8);
    `CHK(pll_run_en, 4'hd)
    `CHK(input_run_en, 4'ha)
    `CHK(drv_on[2], 1'b0)
    `CHK(clk_oe[3], 1'b0)
    `CHK(clk_oe[2], 1'b1)
    pll_pwr_dn = 4'h0;
    input_pwr_dn = 4'h0;
    wr(2, CFG_DEFAULT);
    wr(3, CFG_DEFAULT);
    // protocol select and wire count, all four combinations
    for (int i = 0; i < 4; i++) begin
      serial_sel_pin = i[1];
      spi_3wire_pin = i[0];
      cyc(4);
      `CHK(serial_is_i2c, i[1])
      `CHK(spi_is_3wire, i[0] & ~i[1])
    end
    // two images accepted, a third refused
    wr(0, 16'h2803);
    burn(2'h1, 1'b0);
    wr(0, 16'h2805);
    burn(2'h2, 1'b0);
    wr(0, 16'h2807);
    burn(2'h2, 1'b1);
    // hard reset reloads the newest image; a write during the load is dropped
    hard_reset_req = 1'b1;
    @(negedge clk);
    hard_reset_req = 1'b0;
    `CHK(init_busy, 1'b1)
    wr(1, 16'h3801);
    `CHK(drv_on, 8'h00)
    `WAIT(init_busy === 1'b0, 20)
    rd(0, 16'h2805);
    rd(1, CFG_DEFAULT);
    // reset pin restarts the load as well
    reset_pin_n = 1'b0;
    `WAIT(init_busy === 1'b1, 6)
    reset_pin_n = 1'b1;
    `WAIT(init_busy === 1'b0, 20)
    `WAIT(drv_on === 8'hff, 40)
    close_out();
  end
endmodule
